/* logic/cmbc_cfg.svh */
/*
 * cmbc_cfg.svh: register offsets, field positions and reset values of the
 * message-buffer control block. Assumes inclusion by bare name, once or more.
 */
`ifndef CMBC_CFG_SVH
`define CMBC_CFG_SVH

`define CMBC_OFS_MASK_EXT_ID 8'h00
`define CMBC_OFS_RX_FULL_LO 8'h04
`define CMBC_OFS_RX_FULL_HI 8'h08
`define CMBC_OFS_RX_OVF_LO 8'h0C
`define CMBC_OFS_RX_OVF_HI 8'h10
`define CMBC_OFS_PAIR_CTL0 8'h20

`define CMBC_RST_FLAGS 16'h0000
`define CMBC_RST_MASK 16'h0000
`define CMBC_RST_CTL 8'h00

`define CMBC_CTL_DIR 7
`define CMBC_CTL_ABT 6
`define CMBC_CTL_ARB 5
`define CMBC_CTL_ERR 4
`define CMBC_CTL_REQ 3
`define CMBC_CTL_AUTO_REMOTE_REPLY_ENABLE 2

`define CMBC_RESP_OKAY 2'h0
`define CMBC_RESP_SLVERR 2'h2

`endif

/* logic/cmbc_pkg.sv */
/*
 * cmbc_pkg: types of the message-buffer control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cmbc_pkg;
  typedef logic [7:0] cmbc_ctl_t;
  typedef enum logic [1:0] {
    CMBC_PRI_LOWEST,
    CMBC_PRI_LOW_MID,
    CMBC_PRI_HIGH_MID,
    CMBC_PRI_HIGHEST
  } cmbc_pri_e;
  typedef enum logic [1:0] {
    CMBC_EVT_SENT,
    CMBC_EVT_ARB_LOST,
    CMBC_EVT_BUS_ERROR,
    CMBC_EVT_ABORTED
  } cmbc_tx_evt_e;
endpackage : cmbc_pkg

/* logic/cmbc_top.sv */
/*
 * cmbc_top: CAN message-buffer control and status behind an AXI4-Lite slave,
 * plus packing of received frames into buffer-RAM words.
 * Assumes a protocol engine that reports one store, one remote frame and one
 * transmit event per cycle at most, and writes the packed words into RAM.
 */
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "cmbc_cfg.svh"

module cmbc_top #(
  parameter int ADDR_W = 8,
  parameter int TX_BUFS = 8,
  parameter int RX_BUFS = 32
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [ADDR_W-1:0] AXI_AWADDR,
  input wire logic AXI_AWVALID,
  output logic AXI_AWREADY,
  input wire logic [31:0] AXI_WDATA,
  input wire logic [3:0] AXI_WSTRB,
  input wire logic AXI_WVALID,
  output logic AXI_WREADY,
  output logic [1:0] AXI_BRESP,
  output logic AXI_BVALID,
  input wire logic AXI_BREADY,
  input wire logic [ADDR_W-1:0] AXI_ARADDR,
  input wire logic AXI_ARVALID,
  output logic AXI_ARREADY,
  output logic [31:0] AXI_RDATA,
  output logic [1:0] AXI_RRESP,
  output logic AXI_RVALID,
  input wire logic AXI_RREADY,
  input wire logic [15:0] FILTER_EID_IN,
  input wire logic [15:0] MSG_EID_IN,
  output logic EID_LOW_MATCH,
  input wire logic RX_STORE_VALID,
  input wire logic [4:0] RX_STORE_BUF,
  input wire logic [4:0] RX_FILTER_HIT,
  input wire logic RX_IDE,
  input wire logic RX_SRR,
  input wire logic [10:0] RX_SID,
  input wire logic [17:0] RX_EID,
  input wire logic RX_RTR,
  input wire logic [3:0] RX_DLC,
  input wire logic RX_REMOTE_VALID,
  input wire logic [2:0] RX_REMOTE_BUF,
  output logic RAM_WR_VALID,
  output logic [4:0] RAM_WR_BUF,
  output logic [15:0] RAM_WORD_SID,
  output logic [15:0] RAM_WORD_EID,
  output logic [15:0] RAM_WORD_DLC,
  output logic [15:0] RAM_WORD_STAT,
  input wire logic TX_EVENT_VALID,
  input wire logic [2:0] TX_EVENT_BUF,
  input wire cmbc_pkg::cmbc_tx_evt_e TX_EVENT_KIND,
  output logic [TX_BUFS-1:0] TX_PENDING,
  output logic [TX_BUFS-1:0] TX_ABORT_REQ,
  output logic TX_NEXT_VALID,
  output logic [2:0] TX_NEXT_BUF,
  output cmbc_pkg::cmbc_pri_e TX_NEXT_PRI
);

  // bus slave state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_do;
  logic [15:0] lane_mask, wr16;
  // register state
  logic [15:0] mask_q, mask_d;
  logic [RX_BUFS-1:0] full_q, full_d, ovf_q, ovf_d;
  cmbc_pkg::cmbc_ctl_t ctl_q [TX_BUFS];
  cmbc_pkg::cmbc_ctl_t ctl_d [TX_BUFS];
  logic [TX_BUFS-1:0] abort_q, abort_d;
  // engine-facing state
  logic match_q, match_d, ram_v_q, ram_v_d;
  logic [4:0] ram_buf_q, ram_buf_d;
  logic [15:0] w_sid_q, w_sid_d, w_eid_q, w_eid_d, w_dlc_q, w_dlc_d, w_stat_q, w_stat_d;
  logic nxt_v_q, nxt_v_d;
  logic [2:0] nxt_buf_q, nxt_buf_d;
  cmbc_pkg::cmbc_pri_e nxt_pri_q, nxt_pri_d;
  logic [TX_BUFS-1:0] cand;
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == `CMBC_OFS_MASK_EXT_ID) || (a == `CMBC_OFS_RX_FULL_LO) ||
      (a == `CMBC_OFS_RX_FULL_HI) || (a == `CMBC_OFS_RX_OVF_LO) ||
      (a == `CMBC_OFS_RX_OVF_HI) ||
      ((a >= `CMBC_OFS_PAIR_CTL0) && (a < ADDR_W'(`CMBC_OFS_PAIR_CTL0 + 2 * TX_BUFS)) &&
      (a[1:0] == 2'h0));
  endfunction : mapped

  assign AXI_AWREADY = !aw_held_q && !bvalid_q;
  assign AXI_WREADY = !w_held_q && !bvalid_q;
  assign AXI_ARREADY = !rvalid_q;
  assign AXI_BVALID = bvalid_q;
  assign AXI_BRESP = bresp_q;
  assign AXI_RVALID = rvalid_q;
  assign AXI_RDATA = rdata_q;
  assign AXI_RRESP = rresp_q;
  assign wr_do = aw_held_q && w_held_q && !bvalid_q;
  assign lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr16 = w_data_q[15:0];

  // address and data are held separately, so either may come first
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (AXI_AWVALID && AXI_AWREADY) begin
      aw_held_d = 1'b1;
      aw_addr_d = AXI_AWADDR;
    end
    if (AXI_WVALID && AXI_WREADY) begin
      w_held_d = 1'b1;
      w_data_d = AXI_WDATA;
      w_strb_d = AXI_WSTRB;
    end
    if (wr_do) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(aw_addr_q) ? `CMBC_RESP_OKAY : `CMBC_RESP_SLVERR;
    end else if (bvalid_q && AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (AXI_ARVALID && AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(AXI_ARADDR) ? `CMBC_RESP_OKAY : `CMBC_RESP_SLVERR;
      rdata_d = 32'h0000_0000;
      unique case (AXI_ARADDR)
        `CMBC_OFS_MASK_EXT_ID: rdata_d[15:0] = mask_q;
        `CMBC_OFS_RX_FULL_LO: rdata_d[15:0] = full_q[15:0];
        `CMBC_OFS_RX_FULL_HI: rdata_d[15:0] = full_q[31:16];
        `CMBC_OFS_RX_OVF_LO: rdata_d[15:0] = ovf_q[15:0];
        `CMBC_OFS_RX_OVF_HI: rdata_d[15:0] = ovf_q[31:16];
        default: begin
          for (int r = 0; r < TX_BUFS / 2; r++) begin
            if (AXI_ARADDR == ADDR_W'(`CMBC_OFS_PAIR_CTL0 + 4 * r)) begin
              rdata_d[15:0] = {ctl_q[2 * r + 1], ctl_q[2 * r]};
            end
          end
        end
      endcase
    end else if (rvalid_q && AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  // flags: clear by writing zero; a store in the same cycle wins
  always_comb begin
    mask_d = mask_q;
    full_d = full_q;
    ovf_d = ovf_q;
    if (wr_do) begin
      unique case (aw_addr_q)
        `CMBC_OFS_MASK_EXT_ID: mask_d = (mask_q & ~lane_mask) | (wr16 & lane_mask);
        `CMBC_OFS_RX_FULL_LO: full_d[15:0] = full_q[15:0] & (wr16 | ~lane_mask);
        `CMBC_OFS_RX_FULL_HI: full_d[31:16] = full_q[31:16] & (wr16 | ~lane_mask);
        `CMBC_OFS_RX_OVF_LO: ovf_d[15:0] = ovf_q[15:0] & (wr16 | ~lane_mask);
        `CMBC_OFS_RX_OVF_HI: ovf_d[31:16] = ovf_q[31:16] & (wr16 | ~lane_mask);
        default: ;
      endcase
    end
    if (RX_STORE_VALID) begin
      full_d[RX_STORE_BUF] = 1'b1;
      ovf_d[RX_STORE_BUF] = ovf_q[RX_STORE_BUF] | full_q[RX_STORE_BUF];
    end
  end

  for (genvar b = 0; b < TX_BUFS; b++) begin : g_buf
    logic sel;
    logic [7:0] wbyte;
    assign sel = wr_do && w_strb_q[b % 2] &&
      (aw_addr_q == ADDR_W'(`CMBC_OFS_PAIR_CTL0 + 4 * (b / 2)));
    assign wbyte = w_data_q[8 * (b % 2) +: 8];
    always_comb begin
      ctl_d[b] = ctl_q[b];
      abort_d[b] = abort_q[b];
      if (TX_EVENT_VALID && TX_EVENT_BUF == 3'(b)) begin
        unique case (TX_EVENT_KIND)
          cmbc_pkg::CMBC_EVT_SENT: begin
            ctl_d[b][`CMBC_CTL_REQ] = 1'b0;
            ctl_d[b][`CMBC_CTL_ABT] = 1'b0;
          end
          cmbc_pkg::CMBC_EVT_ARB_LOST: ctl_d[b][`CMBC_CTL_ARB] = 1'b1;
          cmbc_pkg::CMBC_EVT_BUS_ERROR: ctl_d[b][`CMBC_CTL_ERR] = 1'b1;
          cmbc_pkg::CMBC_EVT_ABORTED: begin
            ctl_d[b][`CMBC_CTL_REQ] = 1'b0;
            ctl_d[b][`CMBC_CTL_ABT] = 1'b1;
          end
        endcase
      end
      if (sel) begin
        ctl_d[b][`CMBC_CTL_DIR] = wbyte[`CMBC_CTL_DIR];
        ctl_d[b][`CMBC_CTL_AUTO_REMOTE_REPLY_ENABLE] = wbyte[`CMBC_CTL_AUTO_REMOTE_REPLY_ENABLE];
        ctl_d[b][1:0] = wbyte[1:0];
        if (wbyte[`CMBC_CTL_REQ] && !ctl_q[b][`CMBC_CTL_REQ]) begin
          ctl_d[b][`CMBC_CTL_REQ] = 1'b1;
          ctl_d[b][6:4] = 3'h0;
        end else if (!wbyte[`CMBC_CTL_REQ] && ctl_q[b][`CMBC_CTL_REQ]) begin
          abort_d[b] = 1'b1;
        end
      end
      if (RX_REMOTE_VALID && RX_REMOTE_BUF == 3'(b) && ctl_q[b][`CMBC_CTL_AUTO_REMOTE_REPLY_ENABLE] &&
          !ctl_q[b][`CMBC_CTL_REQ]) begin
        ctl_d[b][`CMBC_CTL_REQ] = 1'b1;
        ctl_d[b][6:4] = 3'h0;
      end
      // abort request only lives while the send request does
      if (!ctl_d[b][`CMBC_CTL_REQ]) begin
        abort_d[b] = 1'b0;
      end
    end
    assign cand[b] = ctl_q[b][`CMBC_CTL_REQ] && ctl_q[b][`CMBC_CTL_DIR] && !abort_q[b];
    assign TX_PENDING[b] = ctl_q[b][`CMBC_CTL_REQ] && ctl_q[b][`CMBC_CTL_DIR];
  end

  assign TX_ABORT_REQ = abort_q;

  // strictly greater wins, so equal priorities go to the lowest buffer
  always_comb begin
    nxt_v_d = 1'b0;
    nxt_buf_d = 3'h0;
    nxt_pri_d = cmbc_pkg::CMBC_PRI_LOWEST;
    for (int b = 0; b < TX_BUFS; b++) begin
      if (cand[b] && (!nxt_v_d || ctl_q[b][1:0] > nxt_pri_d)) begin
        nxt_v_d = 1'b1;
        nxt_buf_d = 3'(b);
        nxt_pri_d = cmbc_pkg::cmbc_pri_e'(ctl_q[b][1:0]);
      end
    end
  end

  // frame packing; unused and reserved bits go out as zero
  always_comb begin
    match_d = ((FILTER_EID_IN ^ MSG_EID_IN) & mask_q) == 16'h0000;
    ram_v_d = RX_STORE_VALID;
    ram_buf_d = RX_STORE_VALID ? RX_STORE_BUF : ram_buf_q;
    w_sid_d = {3'h0, RX_SID, RX_SRR, RX_IDE};
    w_eid_d = {4'h0, RX_EID[17:6]};
    w_dlc_d = {RX_EID[5:0], RX_RTR, 1'b0, 3'h0, 1'b0, RX_DLC};
    w_stat_d = {3'h0, RX_FILTER_HIT, 8'h00};
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CMBC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CMBC_RESP_OKAY;
      mask_q <= `CMBC_RST_MASK;
      full_q <= '0;
      ovf_q <= '0;
      abort_q <= '0;
      for (int b = 0; b < TX_BUFS; b++) begin
        ctl_q[b] <= `CMBC_RST_CTL;
      end
      match_q <= 1'b0;
      ram_v_q <= 1'b0;
      ram_buf_q <= 5'h00;
      w_sid_q <= 16'h0000;
      w_eid_q <= 16'h0000;
      w_dlc_q <= 16'h0000;
      w_stat_q <= 16'h0000;
      nxt_v_q <= 1'b0;
      nxt_buf_q <= 3'h0;
      nxt_pri_q <= cmbc_pkg::CMBC_PRI_LOWEST;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      mask_q <= mask_d;
      full_q <= full_d;
      ovf_q <= ovf_d;
      abort_q <= abort_d;
      ctl_q <= ctl_d;
      match_q <= match_d;
      ram_v_q <= ram_v_d;
      ram_buf_q <= ram_buf_d;
      w_sid_q <= w_sid_d;
      w_eid_q <= w_eid_d;
      w_dlc_q <= w_dlc_d;
      w_stat_q <= w_stat_d;
      nxt_v_q <= nxt_v_d;
      nxt_buf_q <= nxt_buf_d;
      nxt_pri_q <= nxt_pri_d;
    end
  end
  assign EID_LOW_MATCH = match_q;
  assign RAM_WR_VALID = ram_v_q;
  assign RAM_WR_BUF = ram_buf_q;
  assign RAM_WORD_SID = w_sid_q;
  assign RAM_WORD_EID = w_eid_q;
  assign RAM_WORD_DLC = w_dlc_q;
  assign RAM_WORD_STAT = w_stat_q;
  assign TX_NEXT_VALID = nxt_v_q;
  assign TX_NEXT_BUF = nxt_buf_q;
  assign TX_NEXT_PRI = nxt_pri_q;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  property p_full_set;
    RX_STORE_VALID |=> full_q[$past(RX_STORE_BUF)];
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag not set");
  property p_ovf_set;
    RX_STORE_VALID && full_q[RX_STORE_BUF] |=> ovf_q[$past(RX_STORE_BUF)];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");
  // any overflow bit that drops must have been cleared by a register write
  property p_ovf_only_sw;
    |($past(ovf_q) & ~ovf_q) |-> $past(wr_do) &&
      ($past(aw_addr_q) == `CMBC_OFS_RX_OVF_LO || $past(aw_addr_q) == `CMBC_OFS_RX_OVF_HI);
  endproperty
  a_ovf_only_sw: assert property (p_ovf_only_sw) else $error("overflow self-cleared");
  property p_req_clears_status;
    $rose(ctl_q[0][`CMBC_CTL_REQ]) |-> ctl_q[0][6:4] == 3'h0;
  endproperty
  a_req_clears_status: assert property (p_req_clears_status) else $error("status kept");
  property p_sent_clears;
    TX_EVENT_VALID && TX_EVENT_BUF == 3'h1 && TX_EVENT_KIND == cmbc_pkg::CMBC_EVT_SENT &&
      !g_buf[1].sel && !RX_REMOTE_VALID |=> !ctl_q[1][`CMBC_CTL_REQ] && !abort_q[1];
  endproperty
  a_sent_clears: assert property (p_sent_clears) else $error("request not cleared");
  property p_abort_req;
    g_buf[0].sel && !g_buf[0].wbyte[`CMBC_CTL_REQ] && ctl_q[0][`CMBC_CTL_REQ] &&
      !TX_EVENT_VALID |=> abort_q[0] ##1 TX_ABORT_REQ[0] || !ctl_q[0][`CMBC_CTL_REQ];
  endproperty
  a_abort_req: assert property (p_abort_req) else $error("abort not requested");
  property p_remote_reply;
    RX_REMOTE_VALID && RX_REMOTE_BUF == 3'h2 && ctl_q[2][`CMBC_CTL_AUTO_REMOTE_REPLY_ENABLE] &&
      !TX_EVENT_VALID |=> ctl_q[2][`CMBC_CTL_REQ] ##1 TX_PENDING[2] || !ctl_q[2][7];
  endproperty
  a_remote_reply: assert property (p_remote_reply) else $error("no auto reply");
  property p_priority;
    cand[0] && cand[1] && ctl_q[1][1:0] > ctl_q[0][1:0] |=> TX_NEXT_BUF != 3'h0;
  endproperty
  a_priority: assert property (p_priority) else $error("lower priority chosen");
  property p_pack;
    RX_STORE_VALID |=> RAM_WR_VALID && RAM_WORD_SID[12:2] == $past(RX_SID) &&
      RAM_WORD_EID[11:0] == $past(RX_EID[17:6]) && RAM_WORD_DLC[15:10] == $past(RX_EID[5:0]) &&
      RAM_WORD_DLC[3:0] == $past(RX_DLC) && RAM_WORD_STAT[12:8] == $past(RX_FILTER_HIT);
  endproperty
  a_pack: assert property (p_pack) else $error("frame words misplaced");
  c_overflow: cover property (RX_STORE_VALID && full_q[RX_STORE_BUF]);
  c_abort: cover property (abort_q[0] ##[1:20] !ctl_q[0][`CMBC_CTL_REQ]);
  c_remote: cover property (RX_REMOTE_VALID ##1 TX_NEXT_VALID);
endmodule : cmbc_top

/* sim/cmbc_engine_model.sv */
/*
 * cmbc_engine_model: behavioural protocol engine.
 * Assumes one caller at a time and a block sampling on the rising clock.
 */
module cmbc_engine_model (
  input wire logic clock,
  output logic st_v,
  output logic [4:0] st_b,
  output logic [4:0] hit,
  output logic extended_frame_select,
  output logic substitute_remote_req,
  output logic [10:0] standard_identifier,
  output logic [17:0] extended_identifier,
  output logic remote_request_flag,
  output logic [3:0] length_code,
  output logic rm_v,
  output logic [2:0] rm_b,
  output logic ev_v,
  output logic [2:0] ev_b,
  output cmbc_pkg::cmbc_tx_evt_e ev_k
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {st_v, st_b, hit, standard_identifier, extended_identifier, extended_frame_select, substitute_remote_req, remote_request_flag, length_code} = 47'h0;
    {rm_v, rm_b, ev_v, ev_b} = 8'h00;
    ev_k = cmbc_pkg::CMBC_EVT_SENT;
  end
  // idle lines show inverted values: stale data must never look fresh
  task automatic store(input logic [4:0] b, input logic [4:0] h, input logic [10:0] s,
                       input logic [17:0] e, input logic [2:0] f, input logic [3:0] l);
    @(posedge clock);
    {st_v, st_b, hit, standard_identifier, extended_identifier, extended_frame_select, substitute_remote_req, remote_request_flag, length_code} <= {1'b1, b, h, s, e, f, l};
    @(posedge clock);
    {st_v, st_b, hit, standard_identifier, extended_identifier, extended_frame_select, substitute_remote_req, remote_request_flag, length_code} <= {1'b0, ~b, ~h, ~s, ~e, ~f, ~l};
  endtask : store
  task automatic remote(input logic [2:0] b);
    @(posedge clock);
    {rm_v, rm_b} <= {1'b1, b};
    @(posedge clock);
    {rm_v, rm_b} <= {1'b0, ~b};
  endtask : remote
  task automatic evt(input logic [2:0] b, input cmbc_pkg::cmbc_tx_evt_e k);
    @(posedge clock);
    {ev_v, ev_b} <= {1'b1, b};
    ev_k <= k;
    @(posedge clock);
    {ev_v, ev_b} <= {1'b0, ~b};
    ev_k <= cmbc_pkg::cmbc_tx_evt_e'(~k);
  endtask : evt
endmodule : cmbc_engine_model

/* sim/cmbc_top_bench.sv */
/*
 * cmbc_top_bench: self-checking bench for cmbc_top over AXI4-Lite.
 * Assumes the engine model beside it drives the store, remote and event inputs; the bench drives the EID compare inputs.
 */
`include "cmbc_cfg.svh"
module cmbc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] f_eid = 16'h0, m_eid = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, match, ram_v, nxt_v;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] ram_b, st_b, hit;
  logic [15:0] w_sid, w_eid, w_dlc, w_stat;
  logic [7:0] pend, abrq;
  logic [2:0] nxt_b, rm_b, ev_b;
  cmbc_pkg::cmbc_pri_e nxt_p;
  cmbc_pkg::cmbc_tx_evt_e ev_k;
  logic st_v, extended_frame_select, substitute_remote_req, remote_request_flag, rm_v, ev_v;
  logic [10:0] standard_identifier;
  logic [17:0] extended_identifier;
  logic [3:0] length_code;
  int fails = 0;
  int samples_checked = 0;
  localparam logic [7:0] CTL0 = `CMBC_OFS_PAIR_CTL0;
  always #2.5 clock = ~clock;
  cmbc_top i_cmbc_top (.CLOCK(clock), .NRST(nrst), .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid),
    .AXI_AWREADY(awready), .AXI_WDATA(wdata), .AXI_WSTRB(4'hF), .AXI_WVALID(wvalid),
    .AXI_WREADY(wready), .AXI_BRESP(bresp), .AXI_BVALID(bvalid), .AXI_BREADY(bready),
    .AXI_ARADDR(araddr), .AXI_ARVALID(arvalid), .AXI_ARREADY(arready), .AXI_RDATA(rdata),
    .AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(rready), .FILTER_EID_IN(f_eid),
    .MSG_EID_IN(m_eid), .EID_LOW_MATCH(match), .RX_STORE_VALID(st_v), .RX_STORE_BUF(st_b),
    .RX_FILTER_HIT(hit), .RX_IDE(extended_frame_select), .RX_SRR(substitute_remote_req), .RX_SID(standard_identifier), .RX_EID(extended_identifier), .RX_RTR(remote_request_flag),
    .RX_DLC(length_code), .RX_REMOTE_VALID(rm_v), .RX_REMOTE_BUF(rm_b), .RAM_WR_VALID(ram_v),
    .RAM_WR_BUF(ram_b), .RAM_WORD_SID(w_sid), .RAM_WORD_EID(w_eid), .RAM_WORD_DLC(w_dlc),
    .RAM_WORD_STAT(w_stat), .TX_EVENT_VALID(ev_v), .TX_EVENT_BUF(ev_b), .TX_EVENT_KIND(ev_k),
    .TX_PENDING(pend), .TX_ABORT_REQ(abrq), .TX_NEXT_VALID(nxt_v), .TX_NEXT_BUF(nxt_b),
    .TX_NEXT_PRI(nxt_p));
  cmbc_engine_model i_cmbc_engine_model (.clock(clock), .st_v(st_v), .st_b(st_b), .hit(hit),
    .extended_frame_select(extended_frame_select), .substitute_remote_req(substitute_remote_req), .standard_identifier(standard_identifier), .extended_identifier(extended_identifier), .remote_request_flag(remote_request_flag), .length_code(length_code), .rm_v(rm_v),
    .rm_b(rm_b), .ev_v(ev_v), .ev_b(ev_b), .ev_k(ev_k));
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // ready sampled at the negedge, so release lands right after the taking edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge clock);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    while (!tb && n < 50) begin
      @(negedge clock);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      if (tb) chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end
    if (!tb) fails++;
    if (!tb) summarize();
  endtask : axw
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 2'b11};
    while (!tr && n < 50) begin
      @(negedge clock);
      ta = arvalid & arready;
      tr = rvalid & rready;
      if (tr) chk("rdata", rdata, e);
      if (tr) chk("rresp", {30'h0, rresp}, {30'h0, er});
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
    end
    if (!tr) fails++;
    if (!tr) summarize();
  endtask : rd
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, `CMBC_RESP_OKAY);
    rd(CTL0, 32'h0, `CMBC_RESP_OKAY);
    chk("next_valid", {31'h0, nxt_v}, 32'h0);
    rd(8'h3C, 32'h0, `CMBC_RESP_SLVERR);
    axw(8'h3C, 32'hFFFF, `CMBC_RESP_SLVERR);
  endtask : t_regs
  task automatic cmp(input logic [15:0] f, input logic [15:0] m, input logic e);
    @(posedge clock);
    {f_eid, m_eid} <= {f, m};
    @(posedge clock);
    @(negedge clock);
    chk("eid_match", {31'h0, match}, {31'h0, e});
  endtask : cmp
  task automatic t_mask();
    cmp(16'hAB34, 16'h1200, 1'b1);
    axw(`CMBC_OFS_MASK_EXT_ID, 32'h00FF, `CMBC_RESP_OKAY);
    rd(`CMBC_OFS_MASK_EXT_ID, 32'h00FF, `CMBC_RESP_OKAY);
    cmp(16'hAB34, 16'h1234, 1'b1);
    cmp(16'hAB34, 16'hAB35, 1'b0);
  endtask : t_mask
  task automatic t_store();
    logic [17:0] e;
    e = 18'h2ABCD;
    i_cmbc_engine_model.store(5'd17, 5'h13, 11'h5A5, e, 3'b101, 4'h8);
    @(negedge clock);
    chk("ram_v", {31'h0, ram_v}, 32'h1);
    chk("ram_b", {27'h0, ram_b}, 32'd17);
    chk("sid_word", {16'h0, w_sid}, {19'h0, 11'h5A5, 2'b01});
    chk("eid_word", {16'h0, w_eid}, {20'h0, e[17:6]});
    chk("dlc_word", {16'h0, w_dlc}, {16'h0, e[5:0], 6'b100000, 4'h8});
    chk("stat_word", {16'h0, w_stat}, {19'h0, 5'h13, 8'h00});
    rd(`CMBC_OFS_RX_FULL_HI, 32'h2, `CMBC_RESP_OKAY);
    rd(`CMBC_OFS_RX_OVF_HI, 32'h0, `CMBC_RESP_OKAY);
    i_cmbc_engine_model.store(5'd17, 5'h13, 11'h5A5, e, 3'b101, 4'h8);
    i_cmbc_engine_model.store(5'd3, 5'h01, 11'h001, e, 3'b000, 4'h0);
    rd(`CMBC_OFS_RX_OVF_HI, 32'h2, `CMBC_RESP_OKAY);
    rd(`CMBC_OFS_RX_FULL_LO, 32'h8, `CMBC_RESP_OKAY);
    axw(`CMBC_OFS_RX_FULL_HI, 32'h0, `CMBC_RESP_OKAY);
    rd(`CMBC_OFS_RX_FULL_HI, 32'h0, `CMBC_RESP_OKAY);
    axw(`CMBC_OFS_RX_OVF_HI, 32'hFFFF, `CMBC_RESP_OKAY);
    rd(`CMBC_OFS_RX_OVF_HI, 32'h2, `CMBC_RESP_OKAY);
    axw(`CMBC_OFS_RX_OVF_HI, 32'h0, `CMBC_RESP_OKAY);
    rd(`CMBC_OFS_RX_OVF_HI, 32'h0, `CMBC_RESP_OKAY);
  endtask : t_store
  task automatic t_ctl();
    axw(CTL0, 32'h898B, `CMBC_RESP_OKAY);
    repeat (2) @(negedge clock);
    chk("pending", {24'h0, pend}, 32'h03);
    chk("next_buf", {29'h0, nxt_b}, 32'h0);
    i_cmbc_engine_model.evt(3'd0, cmbc_pkg::CMBC_EVT_ARB_LOST);
    rd(CTL0, 32'h89AB, `CMBC_RESP_OKAY);
    i_cmbc_engine_model.evt(3'd0, cmbc_pkg::CMBC_EVT_BUS_ERROR);
    rd(CTL0, 32'h89BB, `CMBC_RESP_OKAY);
    i_cmbc_engine_model.evt(3'd1, cmbc_pkg::CMBC_EVT_SENT);
    rd(CTL0, 32'h81BB, `CMBC_RESP_OKAY);
    axw(CTL0, 32'h81F3, `CMBC_RESP_OKAY);
    rd(CTL0, 32'h81BB, `CMBC_RESP_OKAY);
    chk("abort_req", {24'h0, abrq}, 32'h01);
    i_cmbc_engine_model.evt(3'd0, cmbc_pkg::CMBC_EVT_ABORTED);
    rd(CTL0, 32'h81F3, `CMBC_RESP_OKAY);
    axw(CTL0, 32'h818B, `CMBC_RESP_OKAY);
    rd(CTL0, 32'h818B, `CMBC_RESP_OKAY);
  endtask : t_ctl
  task automatic t_remote();
    axw(CTL0 + 8'h04, 32'h8084, `CMBC_RESP_OKAY);
    i_cmbc_engine_model.remote(3'd2);
    i_cmbc_engine_model.remote(3'd3);
    rd(CTL0 + 8'h04, 32'h808C, `CMBC_RESP_OKAY);
    axw(CTL0, 32'h8988, `CMBC_RESP_OKAY);
    axw(CTL0 + 8'h08, 32'h8A8A, `CMBC_RESP_OKAY);
    repeat (2) @(negedge clock);
    chk("pending", {24'h0, pend}, 32'h37);
    chk("next_valid", {31'h0, nxt_v}, 32'h1);
    chk("next_buf", {29'h0, nxt_b}, 32'h4);
    chk("next_pri", {30'h0, nxt_p}, {30'h0, cmbc_pkg::CMBC_PRI_HIGH_MID});
  endtask : t_remote
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_mask();
    t_store();
    t_ctl();
    t_remote();
    summarize();
  end
endmodule : cmbc_top_bench
